// [cal_accum_pkg.sv]
// constants shared by the calibration test accumulator
package cal_accum_pkg;
   localparam int unsigned CLK_NS       = 10;              // clock period in ns
   localparam int unsigned BOOT_NS      = 1_000_000_000;   // delay before test mode entry
   localparam int unsigned SEC_NS       = 1_000_000_000;   // pulse emission tick period
   localparam int unsigned PULSE_HI_NS  = 2_000_000;       // least output pulse width
   localparam int unsigned PULSE_GAP_NS = 30_000_000;      // pause between pulses
   localparam int unsigned IVAL_NORM_NS = 4_000_000;       // normal measuring interval
   localparam int unsigned BOOT_CYC     = BOOT_NS / CLK_NS;
   localparam int unsigned SEC_CYC      = SEC_NS / CLK_NS;
   localparam int unsigned PULSE_HI_CYC = (PULSE_HI_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned GAP_CYC      = PULSE_GAP_NS / CLK_NS;
   localparam int unsigned IVAL_CYC     = IVAL_NORM_NS / CLK_NS;
   localparam int unsigned TEST_DIV     = 4;               // test mode speed-up
   localparam int unsigned FRAC_BITS    = 8;               // volume fraction bits per pulse
   localparam int unsigned RST_CNT      = 0;               // counters after reset

   // operating mode
   typedef enum logic [1:0] {
      MODE_BOOT   = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_TEST   = 2'b10
   } mode_t;

   // gated test sequence
   typedef enum logic [2:0] {
      G_IDLE  = 3'b000,
      G_FIRST = 3'b001,
      G_RUN   = 3'b010,
      G_LAST  = 3'b011,
      G_DONE  = 3'b100
   } gate_t;
endpackage

// [cal_accum.sv]
// test mode, gated volume accumulation, pulse emission and serial result readout
`timescale 1ns/1ps

module cal_accum #(
   parameter int unsigned VOL_W     = 16,
   parameter int unsigned ACC_W     = 32,
   parameter int unsigned BOOT_CYC  = cal_accum_pkg::BOOT_CYC,
   parameter int unsigned SEC_CYC   = cal_accum_pkg::SEC_CYC,
   parameter int unsigned IVAL_CYC  = cal_accum_pkg::IVAL_CYC,
   parameter int unsigned HI_CYC    = cal_accum_pkg::PULSE_HI_CYC,
   parameter int unsigned GAP_CYC   = cal_accum_pkg::GAP_CYC
) (
   // clock and power-up reset
   input  wire logic             clock,
   input  wire logic             arst_n,
   // verification input, low while grounded
   input  wire logic             verif_n,
   // interval volume from the measuring routine
   input  wire logic             vol_valid,
   input  wire logic [VOL_W-1:0] vol_data,
   // measuring routine trigger and mode
   output logic                  meas_start,
   output logic                  test_mode,
   // volume pulse output
   output logic                  pulse_out,
   // serial readout
   input  wire logic             read_req,
   output logic                  result_ready,
   output logic                  ser_bit,
   output logic                  ser_valid
);
   localparam int unsigned IVAL_TEST = IVAL_CYC / cal_accum_pkg::TEST_DIV;

   typedef struct packed {
      cal_accum_pkg::mode_t mode;
      cal_accum_pkg::gate_t gst;
      logic                 tmode;
      logic                 strap;
      logic                 strap_taken;
      logic                 armed;
      logic                 gate_prev;
      logic                 meas;
      logic [31:0]          boot_cnt;
      logic [31:0]          ival_cnt;
      logic [31:0]          start_partial_after;
      logic [31:0]          stop_partial_before;
      logic [ACC_W-1:0]     acc;
      logic [ACC_W-1:0]     result;
      logic                 result_ok;
      logic [31:0]          sec_cnt;
      logic [ACC_W-1:0]     sec_vol;
      logic [ACC_W-1:0]     pulse_left;
      logic [31:0]          pulse_tmr;
      logic                 pulse;
      logic [ACC_W-1:0]     shreg;
      logic [7:0]           sh_cnt;
      logic                 ser_bit;
      logic                 ser_vld;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic                  gate_now;
   logic                  gate_rise;
   logic                  gate_fall;
   logic                  sec_tick;
   logic [31:0]           ival_len;
   logic [VOL_W+31:0]     prod_s;
   logic [VOL_W+31:0]     part_s;

   // gate is honoured only once the input was seen released in test mode
   assign gate_now  = s_q.tmode & s_q.armed & ~verif_n;
   assign gate_rise = gate_now & ~s_q.gate_prev;
   assign gate_fall = ~gate_now & s_q.gate_prev;
   assign sec_tick  = (s_q.sec_cnt == SEC_CYC - 1);
   assign ival_len  = s_q.tmode ? IVAL_TEST : IVAL_CYC;
   // pro rata share of a partial interval
   assign prod_s    = {32'h0, vol_data} * ((s_q.gst == cal_accum_pkg::G_FIRST) ?
                      {{VOL_W{1'b0}}, s_q.start_partial_after} :
                      {{VOL_W{1'b0}}, s_q.stop_partial_before});
   assign part_s    = prod_s / IVAL_TEST;

   // next state of the whole block
   always_comb begin
      s_d      = s_q;
      s_d.meas = 1'b0;
      // catch the strap just after release, then wait one second
      if (!s_q.strap_taken) begin
         s_d.strap       = ~verif_n;
         s_d.strap_taken = 1'b1;
      end
      if (s_q.mode == cal_accum_pkg::MODE_BOOT) begin
         if (s_q.boot_cnt == BOOT_CYC - 1) begin
            s_d.mode  = s_q.strap ? cal_accum_pkg::MODE_TEST : cal_accum_pkg::MODE_NORMAL;
            // set once here, only reset clears it
            s_d.tmode = s_q.strap;
         end else begin
            s_d.boot_cnt = s_q.boot_cnt + 32'h1;
         end
      end
      // arm the gate once the bench has let go of the input
      if (s_q.tmode && verif_n) begin
         s_d.armed = 1'b1;
      end
      s_d.gate_prev = gate_now;
      if (s_q.ival_cnt >= ival_len - 32'h1) begin
         s_d.ival_cnt = 32'h0;
         s_d.meas     = 1'b1;
      end else begin
         s_d.ival_cnt = s_q.ival_cnt + 32'h1;
      end
      case (s_q.gst)
         cal_accum_pkg::G_IDLE, cal_accum_pkg::G_DONE: begin
            if (gate_rise) begin
               s_d.start_partial_after = ival_len - s_q.ival_cnt;
               s_d.acc                 = '0;
               s_d.result_ok           = 1'b0;
               s_d.gst                 = cal_accum_pkg::G_FIRST;
            end
         end
         cal_accum_pkg::G_FIRST: begin
            // only the share after start counts
            if (vol_valid) begin
               s_d.acc = s_q.acc + part_s[ACC_W-1:0];
               s_d.gst = cal_accum_pkg::G_RUN;
            end
            if (gate_fall) begin
               s_d.stop_partial_before = s_q.ival_cnt;
               s_d.gst                 = cal_accum_pkg::G_LAST;
            end
         end
         cal_accum_pkg::G_RUN: begin
            // same interval volumes as the pulse path
            if (vol_valid) begin
               s_d.acc = s_q.acc + {{(ACC_W-VOL_W){1'b0}}, vol_data};
            end
            if (gate_fall) begin
               s_d.stop_partial_before = s_q.ival_cnt;
               s_d.gst                 = cal_accum_pkg::G_LAST;
            end
         end
         cal_accum_pkg::G_LAST: begin
            // last interval scaled by time until stop
            if (vol_valid) begin
               s_d.result    = s_q.acc + part_s[ACC_W-1:0];
               s_d.result_ok = 1'b1;
               s_d.gst       = cal_accum_pkg::G_DONE;
            end
         end
         default: begin
            s_d.gst = cal_accum_pkg::G_IDLE;
         end
      endcase
      // one-second tick adds the second's whole pulses to the pulse budget
      if (sec_tick) begin
         s_d.sec_cnt    = 32'h0;
         s_d.pulse_left = s_q.pulse_left + (s_q.sec_vol >> cal_accum_pkg::FRAC_BITS);
         s_d.sec_vol    = vol_valid ? {{(ACC_W-VOL_W){1'b0}}, vol_data} : '0;
      end else begin
         s_d.sec_cnt = s_q.sec_cnt + 32'h1;
         if (vol_valid) begin
            s_d.sec_vol = s_q.sec_vol + {{(ACC_W-VOL_W){1'b0}}, vol_data};
         end
      end
      // pulse bursts with fixed width and pause
      if (s_q.pulse_tmr != 32'h0) begin
         s_d.pulse_tmr = s_q.pulse_tmr - 32'h1;
      end else if (s_q.pulse) begin
         s_d.pulse     = 1'b0;
         s_d.pulse_tmr = GAP_CYC - 1;
      end else if (s_q.pulse_left != '0) begin
         s_d.pulse      = 1'b1;
         s_d.pulse_left = s_d.pulse_left - ACC_W'(1);
         s_d.pulse_tmr  = HI_CYC - 1;
      end
      // end of gated test drops pending pulses
      if (gate_fall) begin
         s_d.pulse      = 1'b0;
         s_d.pulse_left = '0;
         s_d.pulse_tmr  = 32'h0;
         s_d.sec_vol    = '0;
      end
      // serial shift-out of the held result, not started during a test
      if (s_q.sh_cnt != 8'h0) begin
         s_d.ser_bit = s_q.shreg[ACC_W-1];
         s_d.ser_vld = 1'b1;
         s_d.shreg   = {s_q.shreg[ACC_W-2:0], 1'b0};
         s_d.sh_cnt  = s_q.sh_cnt - 8'h1;
      end else begin
         s_d.ser_vld = 1'b0;
         if (read_req && s_q.result_ok && s_q.gst == cal_accum_pkg::G_DONE && !gate_now) begin
            s_d.shreg  = s_q.result;
            s_d.sh_cnt = 8'(ACC_W);
         end
      end
   end

   // state register; power removal is the only reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign meas_start   = s_q.meas;
   assign test_mode    = s_q.tmode;
   assign pulse_out    = s_q.pulse;
   assign result_ready = s_q.result_ok;
   assign ser_bit      = s_q.ser_bit;
   assign ser_valid    = s_q.ser_vld;

   // helper: cycles between measuring triggers
   logic [31:0] gap_q;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         gap_q <= 32'h0;
      end else begin
         gap_q <= s_q.meas ? 32'h1 : gap_q + 32'h1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence boot_end_grounded;
      s_q.mode == cal_accum_pkg::MODE_BOOT && s_q.boot_cnt == BOOT_CYC - 1 && s_q.strap;
   endsequence
   sequence test_stopped;
      gate_fall && s_q.tmode;
   endsequence

   a_quarter_interval: assert property (
      s_q.meas && s_q.tmode && $past(s_q.tmode, 2) && gap_q < 32'(IVAL_CYC)
      |-> gap_q == IVAL_TEST) else $error("test interval wrong");
   a_test_entry: assert property (boot_end_grounded |=> test_mode)
      else $error("test mode not entered");
   a_mode_sticky: assert property (test_mode |=> test_mode)
      else $error("test mode left");
   a_accum_gated: assert property (
      s_q.gst == cal_accum_pkg::G_RUN && !vol_valid && !gate_fall |=> $stable(s_q.acc))
      else $error("acc moved without volume");
   a_run_adds: assert property (
      s_q.gst == cal_accum_pkg::G_RUN && vol_valid
      |=> s_q.acc == $past(s_q.acc) + $past(vol_data)) else $error("volume not added");
   a_result_hold: assert property (
      s_q.gst == cal_accum_pkg::G_DONE && !gate_rise |=> $stable(s_q.result))
      else $error("result changed");
   a_pulse_stop: assert property (test_stopped |=> !pulse_out ##1 !pulse_out)
      else $error("pulse after stop");
   a_sec_reload: assert property (
      sec_tick && !gate_fall && (s_q.pulse_tmr != 32'h0 || s_q.pulse || s_q.pulse_left == '0)
      |=> s_q.pulse_left == $past(s_q.pulse_left)
          + ($past(s_q.sec_vol) >> cal_accum_pkg::FRAC_BITS))
      else $error("pulse budget wrong");
   a_read_burst: assert property (
      read_req && s_q.sh_cnt == 8'h0 && s_q.result_ok && s_q.gst == cal_accum_pkg::G_DONE
      && !gate_now |=> ##1 ser_valid [*8]) else $error("serial burst short");
endmodule // cal_accum

// [cal_bench_model.sv]
// calibration bench model: gate drive, interval volume source and serial reader
`timescale 1ns/1ps
module cal_bench_model (
   // clock
   input  wire logic        clock,
   // device outputs
   input  wire logic        meas_start,
   input  wire logic        ser_bit,
   input  wire logic        ser_valid,
   // bench drive
   output logic             verif_n,
   output logic             vol_valid,
   output logic [15:0]      vol_data,
   output logic             read_req
);
   logic [15:0] vol_amount;
   logic [31:0] rx_word;
   int          rx_bits = 0;

   // idle values at time zero
   initial begin
      verif_n = 1'b1;
      vol_valid = 1'b0;
      vol_data = 16'h0000;
      read_req = 1'b0;
      vol_amount = 16'h0000;
   end

   // one interval volume after each boundary, data toggles while unqualified
   always @(negedge clock) begin
      vol_valid <= meas_start;
      vol_data  <= meas_start ? vol_amount : ~vol_data;
   end

   // shift in the result, msb first
   always @(posedge clock) begin
      if (ser_valid === 1'b1) begin
         rx_word <= {rx_word[30:0], ser_bit};
         rx_bits <= rx_bits + 1;
      end
   end

   // ground to start, release to stop
   task automatic run_gate(input int cycles);
      @(negedge clock) verif_n = 1'b0;
      repeat (cycles) @(negedge clock);
      verif_n = 1'b1;
   endtask

   // read only after the wait, never during a gate
   task automatic read_result(input int wait_cyc, output logic [31:0] word, output int bits);
      int base;
      repeat (wait_cyc) @(negedge clock);
      base = rx_bits;
      read_req = 1'b1;
      @(negedge clock) read_req = 1'b0;
      repeat (40) @(negedge clock);
      word = rx_word;
      bits = rx_bits - base;
   endtask

   // strap or gate level on the verification input
   task automatic set_level(input logic level);
      verif_n = level;
   endtask

   // volume reported for each interval
   task automatic set_amount(input logic [15:0] amount);
      vol_amount = amount;
   endtask
endmodule // cal_bench_model

// [tb_top.sv]
// self-checking testbench for the calibration test accumulator
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb_top;
   localparam int unsigned BOOT = 20;
   localparam int unsigned SEC  = 200;
   localparam int unsigned IVAL = 40;
   int          mismatches  = 0;
   int          comparisons = 0;
   logic        clock, arst_n, verif_n, vol_valid, read_req;
   logic [15:0] vol_data;
   logic        meas_start, test_mode, pulse_out, result_ready, ser_bit, ser_valid;
   logic [31:0] word_a, word_b;
   int          bits;

   // design with shortened counts
   cal_accum #(.BOOT_CYC(BOOT), .SEC_CYC(SEC), .IVAL_CYC(IVAL), .HI_CYC(2), .GAP_CYC(4)) i_dut (
      .clock(clock), .arst_n(arst_n), .verif_n(verif_n), .vol_valid(vol_valid),
      .vol_data(vol_data), .meas_start(meas_start), .test_mode(test_mode),
      .pulse_out(pulse_out), .read_req(read_req), .result_ready(result_ready),
      .ser_bit(ser_bit), .ser_valid(ser_valid));

   // far side bench
   cal_bench_model i_bench (
      .clock(clock), .meas_start(meas_start), .ser_bit(ser_bit), .ser_valid(ser_valid),
      .verif_n(verif_n), .vol_valid(vol_valid), .vol_data(vol_data), .read_req(read_req));

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic report_and_stop;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // power removed for 8 cycles with the strap level applied
   task automatic power_up(input logic strap);
      arst_n = 1'b0;
      i_bench.set_level(strap);
      repeat (8) @(negedge clock);
      arst_n = 1'b1;
   endtask

   task automatic boot_check(input logic exp_mode);
      repeat (BOOT - 4) @(negedge clock);
      `CHK(test_mode, 1'b0)
      repeat (10) @(negedge clock);
      `CHK(test_mode, exp_mode)
      i_bench.set_level(1'b1);
   endtask

   task automatic interval_check(input int exp);
      int n;
      n = 0;
      while (meas_start !== 1'b1 && n < 500) begin
         @(negedge clock);
         n++;
      end
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (meas_start !== 1'b1 && n < 500);
      `CHK(n, exp)
   endtask

   // gated test across a second tick, so pulses are pending at stop:
   // 172 cycles at 16 units per cycle gives 2752
   task automatic gate_check;
      int hi, n;
      hi = 0;
      n = 0;
      i_bench.set_amount(16'h00A0);
      i_bench.run_gate(172);
      @(negedge clock);
      repeat (5) begin
         @(negedge clock);
         if (pulse_out !== 1'b0) hi++;
      end
      `CHK(hi, 0)
      while (result_ready !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      `CHK(result_ready, 1'b1)
      i_bench.read_result(2 * SEC, word_a, bits);
      `CHK(bits, 32)
      `CHK(word_a, 32'h00000AC0)
      i_bench.read_result(10, word_b, bits);
      `CHK(word_b, word_a)
      `CHK(test_mode, 1'b1)
   endtask

   // normal mode: one pulse per interval, five per second
   task automatic pulse_check;
      int edges;
      logic prev;
      edges = 0;
      prev = 1'b0;
      i_bench.set_amount(16'h0100);
      repeat (SEC) @(negedge clock);
      repeat (3 * SEC) begin
         @(negedge clock);
         if (pulse_out === 1'b1 && !prev) edges++;
         prev = (pulse_out === 1'b1);
      end
      `CHK(edges >= 10 && edges <= 16, 1'b1)
   endtask

   // main sequence: test mode run, then a power cycle into normal mode
   initial begin
      arst_n = 1'b0;
      power_up(1'b0);
      boot_check(1'b1);
      interval_check(IVAL / 4);
      gate_check;
      power_up(1'b1);
      boot_check(1'b0);
      interval_check(IVAL);
      pulse_check;
      report_and_stop;
   end

   // watchdog well beyond the expected run of about 1600 cycles
   initial begin
      repeat (8000) @(posedge clock);
      mismatches++;
      report_and_stop;
   end
endmodule // tb_top
